// ---- rtl/frame_loss_detector.sv ----
// Purpose: T3 frame loss from F and M bit error windows
// Assumes: one strobe per received overhead bit
// Notes:   held until the framer reports resynchronisation
`timescale 1ns/1ns
`default_nettype none
module frame_loss_detector #(
  parameter logic [4:0] F_LIMIT = framer_irq_pkg::F_ERR_LIMIT,
  parameter logic [4:0] M_LIMIT = framer_irq_pkg::M_ERR_LIMIT
) (
  // clock and control
  input  wire logic     mclk,
  input  wire logic     rst,
  input  wire logic     ce,
  // overhead bits
  overhead_if.loss_side ovh
);
  logic [15:0] f_hist;
  logic [3:0]  m_hist;
  logic [15:0] next_f_hist;
  logic [3:0]  next_m_hist;
  logic        f_trip;
  logic        m_trip;
  logic        lost;

  assign next_f_hist = {f_hist[14:0], ovh.f_err};
  assign next_m_hist = {m_hist[2:0], ovh.m_err};
  assign f_trip = ovh.f_valid &&
                  framer_irq_pkg::ones16(next_f_hist) >= F_LIMIT; // RULE_14
  assign m_trip = ovh.m_valid &&
                  framer_irq_pkg::ones16({12'h000, next_m_hist})
                  >= M_LIMIT; // RULE_14
  assign ovh.frame_lost = lost;

  // history restarts on resync so old errors do not retrip
  always_ff @(posedge mclk) begin
    if (rst) begin
      f_hist <= 16'h0000;
      m_hist <= 4'h0;
    end else if (ce) begin
      if (ovh.resync) begin
        f_hist <= 16'h0000;
        m_hist <= 4'h0;
      end else begin
        if (ovh.f_valid) f_hist <= next_f_hist;
        if (ovh.m_valid) m_hist <= next_m_hist;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      lost <= 1'b0;
    end else if (ce) begin
      if (f_trip || m_trip) lost <= 1'b1; // RULE_14
      else if (ovh.resync) lost <= 1'b0;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  f_window_trip_a: assert property ( // RULE_14
      ce && !ovh.resync && f_trip |=> lost)
    else $error("frame loss missed on F bit errors");
  m_window_trip_a: assert property ( // RULE_14
      ce && ovh.m_valid && ovh.m_err && m_hist[0] && !ovh.resync
      |=> lost)
    else $error("frame loss missed on M bit errors");
endmodule : frame_loss_detector
`default_nettype wire

// ---- rtl/framer_irq_pkg.sv ----
// Purpose: shared constants for the framer status and interrupt block
// Assumes: one 250 MHz clock, plain register port, 8-bit byte offsets
// Notes:   bit layout is shared by the status and the mask register
//
// Behaviour
// (RULE_01) bit 0 latches signal loss, sticky while present
// (RULE_02) bit 1 latches frame loss, sticky while present
// (RULE_03) bit 2 latches alarm indication, sticky while present
// (RULE_04) bit 3 latches remote alarm, sticky while present
// (RULE_05) bit 4 latches idle pattern, sticky while present
// (RULE_06) software ignores idle bit in E3 mode
// (RULE_07) alarm change interrupts when both masks set
// (RULE_08) alarm interrupt pending until status read; code also releases it on a status write of one
// (RULE_09) bit 5 sets each tx frame, read clears
// (RULE_10) bit 6 sets each rx frame, read clears
// (RULE_11) frame event setting interrupts when both masks set
// (RULE_12) mask register bits 0-6, one unmasks, reset zero
// (RULE_13) C-bit remote alarm codes reported apart
// (RULE_14) frame loss: 3 of 16 F or 2 of 4 M bits bad
// (RULE_15) remote alarm clears after 4 multiframes of ones
// (RULE_16) bits 7-15 read zero, ignore writes
package framer_irq_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int NUM_BITS = 7;
  localparam int NUM_ALARMS = 5;

  // register offsets
  localparam logic [7:0] STATUS_OFFSET  = 8'h12;
  localparam logic [7:0] MASK_OFFSET    = 8'h14;
  localparam logic [7:0] CONTROL_OFFSET = 8'h1e;
  localparam logic [7:0] LIVE_OFFSET    = 8'h20;

  // status and mask bit positions
  localparam int BIT_SIGNAL_LOST = 0;
  localparam int BIT_FRAME_LOST  = 1;
  localparam int BIT_ALARM_IND   = 2;
  localparam int BIT_REMOTE      = 3;
  localparam int BIT_IDLE        = 4;
  localparam int BIT_TX_START    = 5;
  localparam int BIT_RX_START    = 6;

  // control register bit positions
  localparam int CTRL_MASTER = 0;
  localparam int CTRL_E3     = 1;
  localparam int CTRL_CBIT   = 2;
  // live register: bits 0-4 conditions, bit 5 C-bit remote alarm code
  localparam int LIVE_CODE_REMOTE = 5;

  // reset values
  localparam logic [6:0] STATUS_RESET  = 7'h00;
  localparam logic [6:0] MASK_RESET    = 7'h00;
  localparam logic [2:0] CONTROL_RESET = 3'h0;

  // overhead bit criteria
  localparam logic [4:0] F_ERR_LIMIT = 5'h03;
  localparam logic [4:0] M_ERR_LIMIT = 5'h02;
  localparam logic [2:0] REMOTE_FRAMES = 3'h4;

  function automatic logic [4:0] ones16(input logic [15:0] v);
    logic [4:0] n;
    n = 5'h00;
    for (int i = 0; i < 16; i++) begin
      n = n + {4'h0, v[i]};
    end
    return n;
  endfunction : ones16

endpackage : framer_irq_pkg

// ---- rtl/framer_status_irq.sv ----
// Purpose: framer alarm and frame event status with interrupt masking
// Assumes: condition and strobe inputs come from logic on mclk
// Notes:   read data stand in the cycle after the read strobe only
`timescale 1ns/1ns
`default_nettype none
module framer_status_irq (
  // clock, reset, enable
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        ce,
  // register port
  input  wire logic [7:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [15:0] rdata,
  // alarm conditions
  input  wire logic        signal_lost,
  input  wire logic        e3_frame_lost,
  input  wire logic        alarm_indication_detected,
  input  wire logic        e3_remote_alarm,
  input  wire logic        idle_pattern_detected,
  input  wire logic        far_end_alarm_control_code,
  // T3 overhead bits
  input  wire logic        f_bit_valid,
  input  wire logic        f_bit_error,
  input  wire logic        m_bit_valid,
  input  wire logic        m_bit_error,
  input  wire logic        frame_sync,
  input  wire logic        x_bits_valid,
  input  wire logic        x1_bit,
  input  wire logic        x2_bit,
  // frame boundaries
  input  wire logic        tx_frame_start,
  input  wire logic        rx_frame_start,
  output logic             tx_frame_start_pin,
  output logic             rx_frame_start_pin,
  // interrupt
  output logic             irq
);
  overhead_if ovh ();

  logic [6:0] status;
  logic [6:0] mask;
  logic [6:0] pending;
  logic [4:0] cond;
  logic [4:0] cond_prev;
  logic [4:0] change;
  logic [6:0] events;
  logic [6:0] live;
  logic       master;
  logic       e3_mode;
  logic       cbit_mode;
  logic       status_rd;
  logic       status_wr;
  logic       mask_wr;
  logic       ctrl_wr;
  logic       frame_cond;
  logic       remote_cond;
  logic       code_remote;

  assign ovh.f_valid = f_bit_valid;
  assign ovh.f_err   = f_bit_error;
  assign ovh.m_valid = m_bit_valid;
  assign ovh.m_err   = m_bit_error;
  assign ovh.resync  = frame_sync;
  assign ovh.x_valid = x_bits_valid;
  assign ovh.x1      = x1_bit;
  assign ovh.x2      = x2_bit;

  frame_loss_detector u_frame_loss (
    .mclk (mclk),
    .rst  (rst),
    .ce   (ce),
    .ovh  (ovh.loss_side)
  );

  remote_alarm_detector u_remote_alarm (
    .mclk (mclk),
    .rst  (rst),
    .ce   (ce),
    .ovh  (ovh.remote_side)
  );

  // T3 uses the local detectors, E3 takes the external criteria
  assign frame_cond  = e3_mode ? e3_frame_lost : ovh.frame_lost; // RULE_14
  assign remote_cond = e3_mode ? e3_remote_alarm : ovh.remote_alarm;
  // code-signalled remote alarm stays out of the status bit
  assign code_remote = cbit_mode && !e3_mode &&
                       far_end_alarm_control_code; // RULE_13

  assign cond = {idle_pattern_detected, remote_cond,
                 alarm_indication_detected, frame_cond, signal_lost};
  assign change = cond ^ cond_prev;
  assign events = {rx_frame_start, tx_frame_start, 5'h00};
  assign live = {1'b0, code_remote, cond};

  assign status_rd = ce && rd && addr == framer_irq_pkg::STATUS_OFFSET;
  assign status_wr = ce && wr && addr == framer_irq_pkg::STATUS_OFFSET;
  assign mask_wr   = ce && wr && addr == framer_irq_pkg::MASK_OFFSET;
  assign ctrl_wr   = ce && wr && addr == framer_irq_pkg::CONTROL_OFFSET;

  // alarm bits follow the condition on read, so a live alarm survives it
  always_ff @(posedge mclk) begin
    if (rst) begin
      status <= framer_irq_pkg::STATUS_RESET;
    end else if (ce) begin
      status[4:0] <= cond |
                     (status[4:0] & ~{5{status_rd}}); // RULE_01 RULE_02 RULE_03 RULE_04 RULE_05
      status[6:5] <= events[6:5] |
                     (status[6:5] & ~{2{status_rd}}); // RULE_09 RULE_10
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      cond_prev <= 5'h00;
    end else if (ce) begin
      cond_prev <= cond;
    end
  end

  // pending: set wins over a clear in the same cycle
  always_ff @(posedge mclk) begin
    if (rst) begin
      pending <= 7'h00;
    end else if (ce) begin
      pending[4:0] <= change | (pending[4:0] & ~{5{status_rd}} &
                      ~(wdata[4:0] & {5{status_wr}})); // RULE_07 RULE_08
      pending[6:5] <= events[6:5] | (pending[6:5] & ~{2{status_rd}} &
                      ~(wdata[6:5] & {2{status_wr}})); // RULE_11
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      mask <= framer_irq_pkg::MASK_RESET;
    end else if (mask_wr) begin
      mask <= wdata[6:0]; // RULE_12 RULE_16
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      {cbit_mode, e3_mode, master} <= framer_irq_pkg::CONTROL_RESET;
    end else if (ctrl_wr) begin
      master    <= wdata[framer_irq_pkg::CTRL_MASTER];
      e3_mode   <= wdata[framer_irq_pkg::CTRL_E3];
      cbit_mode <= wdata[framer_irq_pkg::CTRL_CBIT];
    end
  end

  // registered so the pin never glitches on mask writes
  always_ff @(posedge mclk) begin
    if (rst) begin
      irq <= 1'b0;
    end else if (ce) begin
      irq <= master && |(pending & mask); // RULE_07 RULE_11
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      tx_frame_start_pin <= 1'b0;
      rx_frame_start_pin <= 1'b0;
    end else if (ce) begin
      tx_frame_start_pin <= tx_frame_start; // RULE_09
      rx_frame_start_pin <= rx_frame_start; // RULE_10
    end
  end

  // unread and unmapped cycles return zero
  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata <= 16'h0000;
    end else if (ce) begin
      rdata <= 16'h0000;
      if (rd) begin
        case (addr)
          framer_irq_pkg::STATUS_OFFSET: rdata <= {9'h000, status}; // RULE_16
          framer_irq_pkg::MASK_OFFSET:   rdata <= {9'h000, mask}; // RULE_16
          framer_irq_pkg::CONTROL_OFFSET:
            rdata <= {13'h0000, cbit_mode, e3_mode, master};
          framer_irq_pkg::LIVE_OFFSET:   rdata <= {9'h000, live};
          default:                       rdata <= 16'h0000;
        endcase
      end
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  signal_lost_set_a: assert property ( // RULE_01
      ce && signal_lost |=> status[0])
    else $error("signal loss not latched");
  signal_lost_clr_a: assert property ( // RULE_01
      ce && status_rd && !signal_lost |=> !status[0])
    else $error("signal loss bit survived read");
  signal_sticky_a: assert property ( // RULE_01
      ce && !status_rd && status[0] |=> status[0])
    else $error("signal loss bit dropped without read");

  frame_lost_set_a: assert property ( // RULE_02
      ce && frame_cond |=> status[1])
    else $error("frame loss not latched");
  frame_lost_clr_a: assert property ( // RULE_02
      ce && status_rd && !frame_cond |=> !status[1])
    else $error("frame loss bit survived read");

  alarm_ind_keep_a: assert property ( // RULE_03
      ce && status_rd && alarm_indication_detected |=> status[2])
    else $error("alarm indication cleared while present");
  alarm_ind_clr_a: assert property ( // RULE_03
      ce && status_rd && !alarm_indication_detected |=> !status[2])
    else $error("alarm indication bit survived read");

  remote_sep_a: assert property ( // RULE_04
      ce && status_rd && !remote_cond |=> !status[3])
    else $error("remote bit set without remote condition");
  remote_set_a: assert property ( // RULE_04
      ce && remote_cond |=> status[3])
    else $error("remote alarm not latched");

  idle_clear_a: assert property ( // RULE_05
      ce && status_rd && !idle_pattern_detected |=> !status[4])
    else $error("idle bit survived read");
  idle_set_a: assert property ( // RULE_05
      ce && idle_pattern_detected |=> status[4])
    else $error("idle pattern not latched");

  // mask and control writes are kept out so the check sees a settled gate
  change_irq_a: assert property ( // RULE_07
      (ce && change[1] && master && mask[1] && !mask_wr && !ctrl_wr)
      ##1 (ce && !mask_wr && !ctrl_wr) |=> irq)
    else $error("alarm change raised no interrupt");
  change_pend_a: assert property ( // RULE_07
      ce && change[2] |=> pending[2])
    else $error("alarm change did not pend");
  master_quiet_a: assert property ( // RULE_07 RULE_11
      ce && !master |=> !irq)
    else $error("interrupt raised with master mask off");

  pending_hold_a: assert property ( // RULE_08
      pending[0] && !status_rd && !status_wr |=> pending[0])
    else $error("alarm request dropped before read");
  pending_rd_a: assert property ( // RULE_08
      ce && status_rd && !change[0] |=> !pending[0])
    else $error("status read did not release request");
  irq_release_a: assert property ( // RULE_08
      (ce && status_rd && change == 5'h00 && !tx_frame_start &&
      !rx_frame_start) ##1 ce |=> !irq)
    else $error("interrupt stayed up after status read");

  tx_event_a: assert property ( // RULE_09
      ce && tx_frame_start |=> status[5] && tx_frame_start_pin)
    else $error("tx frame start not mirrored");
  tx_read_clr_a: assert property ( // RULE_09
      ce && status_rd && !tx_frame_start |=> !status[5])
    else $error("tx frame bit survived read");
  tx_pin_pulse_a: assert property ( // RULE_09
      ce && !tx_frame_start |=> !tx_frame_start_pin)
    else $error("tx frame pin longer than one cycle");

  rx_event_a: assert property ( // RULE_10
      ce && rx_frame_start |=> status[6] && rx_frame_start_pin)
    else $error("rx frame start not mirrored");
  rx_read_clr_a: assert property ( // RULE_10
      ce && status_rd && !rx_frame_start |=> !status[6])
    else $error("rx frame bit survived read");

  event_irq_a: assert property ( // RULE_11
      (ce && rx_frame_start && master && mask[6] && !mask_wr && !ctrl_wr)
      ##1 (ce && !mask_wr && !ctrl_wr) |=> irq)
    else $error("rx frame event raised no interrupt");
  event_pend_a: assert property ( // RULE_11
      ce && tx_frame_start |=> pending[5])
    else $error("tx frame event did not pend");

  mask_write_a: assert property ( // RULE_12
      mask_wr |=> mask == $past(wdata[6:0]))
    else $error("mask register did not take write");
  mask_hold_a: assert property ( // RULE_12
      !mask_wr |=> $stable(mask))
    else $error("mask register changed without write");

  code_live_a: assert property ( // RULE_13
      ce && rd && addr == framer_irq_pkg::LIVE_OFFSET
      |=> rdata[framer_irq_pkg::LIVE_CODE_REMOTE] == $past(code_remote))
    else $error("code remote alarm not reported");
  code_apart_a: assert property ( // RULE_13
      ce && status_rd && code_remote && !remote_cond |=> !status[3])
    else $error("code remote alarm leaked into status");

  upper_zero_a: assert property ( // RULE_16
      ce && rd |=> rdata[15:7] == 9'h000)
    else $error("upper register bits not zero");

  irq_raised_c: cover property (ce && change[0] ##[1:4] irq);
  read_clear_c: cover property (status_rd && status[6] ##1 !status[6]);
  live_read_c: cover property (status_rd && signal_lost ##1 status[0]);
  code_alarm_c: cover property (code_remote && !remote_cond);
  masked_change_c: cover property (ce && change[0] && !mask[0]);
endmodule : framer_status_irq
`default_nettype wire

// ---- rtl/overhead_if.sv ----
// Purpose: carries overhead bit samples to the alarm detectors
// Assumes: all signals on mclk
// Notes:   strobes are one cycle wide
`timescale 1ns/1ns
`default_nettype none
interface overhead_if;
  logic f_valid;
  logic f_err;
  logic m_valid;
  logic m_err;
  logic resync;
  logic x_valid;
  logic x1;
  logic x2;
  logic frame_lost;
  logic remote_alarm;

  modport framer (
    output f_valid, f_err, m_valid, m_err, resync, x_valid, x1, x2,
    input  frame_lost, remote_alarm
  );
  modport loss_side (
    input  f_valid, f_err, m_valid, m_err, resync,
    output frame_lost
  );
  modport remote_side (
    input  x_valid, x1, x2,
    output remote_alarm
  );
endinterface : overhead_if
`default_nettype wire

// ---- rtl/remote_alarm_detector.sv ----
// Purpose: T3 remote alarm from the two X bits per multiframe
// Assumes: x_valid strobes once per multiframe
// Notes:   a mixed X bit pair restarts both counts
`timescale 1ns/1ns
`default_nettype none
module remote_alarm_detector #(
  parameter logic [2:0] FRAMES = framer_irq_pkg::REMOTE_FRAMES
) (
  // clock and control
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       ce,
  // overhead bits
  overhead_if.remote_side ovh
);
  logic [2:0] set_cnt;
  logic [2:0] clr_cnt;
  logic       active;
  logic       zeros;
  logic       ones;

  assign zeros = ovh.x_valid && !ovh.x1 && !ovh.x2;
  assign ones  = ovh.x_valid && ovh.x1 && ovh.x2;
  assign ovh.remote_alarm = active;

  always_ff @(posedge mclk) begin
    if (rst) begin
      set_cnt <= 3'h0;
      clr_cnt <= 3'h0;
    end else if (ce && ovh.x_valid) begin
      set_cnt <= zeros ? ((set_cnt == FRAMES) ? set_cnt : set_cnt + 3'h1)
                       : 3'h0;
      clr_cnt <= ones ? ((clr_cnt == FRAMES) ? clr_cnt : clr_cnt + 3'h1)
                      : 3'h0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      active <= 1'b0;
    end else if (ce) begin
      if (zeros && set_cnt >= FRAMES - 3'h1) active <= 1'b1;
      else if (ones && clr_cnt >= FRAMES - 3'h1) active <= 1'b0; // RULE_15
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  remote_clear_a: assert property ( // RULE_15
      ce && ones && clr_cnt == FRAMES - 3'h1 |=> !active)
    else $error("remote alarm did not clear");
  remote_early_a: assert property ( // RULE_15
      ce && ones && clr_cnt == 3'h0 && active |=> active)
    else $error("remote alarm cleared too early");
endmodule : remote_alarm_detector
`default_nettype wire

// ---- test/testbench.sv ----
// Purpose: self-checking bench for the framer status and interrupt block
// Assumes: ce high except for one frozen-strobe check
// Notes:   plain bit cases run from a table in E3 mode, detectors by hand
`timescale 1ns/1ns
`default_nettype none
module testbench;
  typedef struct packed {
    logic [2:0]  idx;
    logic [15:0] mask;
    logic        exp_irq;
  } row_t;

  logic        mclk;
  logic        rst;
  logic        ce;
  logic [7:0]  addr;
  logic [15:0] wdata;
  logic        wr;
  logic        rd;
  logic [15:0] rdata;
  logic [4:0]  cond;
  logic        far_code;
  logic        f_valid;
  logic        f_err;
  logic        m_valid;
  logic        m_err;
  logic        sync;
  logic        x_valid;
  logic        x_val;
  logic        tx_start;
  logic        rx_start;
  logic        tx_pin;
  logic        rx_pin;
  logic        irq;
  int          fails;
  int          n_compared;
  int          cycles;
  row_t        rows [9];

  framer_status_irq DUT (
    .mclk(mclk), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata),
    .signal_lost(cond[0]), .e3_frame_lost(cond[1]),
    .alarm_indication_detected(cond[2]), .e3_remote_alarm(cond[3]),
    .idle_pattern_detected(cond[4]),
    .far_end_alarm_control_code(far_code),
    .f_bit_valid(f_valid), .f_bit_error(f_err),
    .m_bit_valid(m_valid), .m_bit_error(m_err), .frame_sync(sync),
    .x_bits_valid(x_valid), .x1_bit(x_val), .x2_bit(x_val),
    .tx_frame_start(tx_start), .rx_frame_start(rx_start),
    .tx_frame_start_pin(tx_pin), .rx_frame_start_pin(rx_pin), .irq(irq)
  );

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // the whole run needs a few hundred cycles
  always @(posedge mclk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      fails++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("compared %0d, mismatched %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask : tick

  task automatic wreg(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : wreg

  // read data are looked at only in the cycle after the strobe
  task automatic rreg(input logic [7:0] a, input logic [15:0] e);
    @(posedge mclk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    chk(rdata, e);
  endtask : rreg

  task automatic irq_at(input logic e);
    @(posedge mclk);
    #1;
    chk({15'h0000, irq}, {15'h0000, e});
  endtask : irq_at

  // k: 0 F bit, 1 M bit, 2 sync, 3 X bits, 4 tx start, 5 rx start
  task automatic pulse(input int k, input logic e);
    @(posedge mclk);
    f_valid  <= (k == 0);
    m_valid  <= (k == 1);
    sync     <= (k == 2);
    x_valid  <= (k == 3);
    tx_start <= (k == 4);
    rx_start <= (k == 5);
    f_err    <= e;
    m_err    <= e;
    x_val    <= e;
    @(posedge mclk);
    {f_valid, m_valid, sync, x_valid, tx_start, rx_start} <= 6'h00;
  endtask : pulse

  task automatic run_row(input row_t r);
    logic [15:0] b;
    b = 16'h0001 << r.idx;
    wreg(framer_irq_pkg::MASK_OFFSET, r.mask);
    if (r.idx < 3'h5) begin
      @(posedge mclk);
      cond <= cond | (5'h01 << r.idx);
    end else begin
      pulse(int'(r.idx) - 1, 1'b0);
      #1;
      chk({14'h0000, tx_pin, rx_pin}, (r.idx == 3'h5) ? 16'h2 : 16'h1);
    end
    tick(2);
    irq_at(r.exp_irq);
    rreg(framer_irq_pkg::STATUS_OFFSET, b);
    irq_at(1'b0);
    if (r.idx < 3'h5) begin
      rreg(framer_irq_pkg::STATUS_OFFSET, b);
      @(posedge mclk);
      cond <= cond & ~(5'h01 << r.idx);
      tick(2);
      irq_at(r.exp_irq);
      rreg(framer_irq_pkg::STATUS_OFFSET, b);
    end
    rreg(framer_irq_pkg::STATUS_OFFSET, 16'h0000);
    irq_at(1'b0);
  endtask : run_row

  task automatic done(input string name);
    $display("test %s finished, mismatches so far %0d", name, fails);
  endtask : done

  initial begin
    {rst, ce} = 2'b11;
    {addr, wdata, wr, rd, cond, far_code} = 32'h0000_0000;
    {f_valid, f_err, m_valid, m_err, sync, x_valid, x_val} = 7'h00;
    {tx_start, rx_start} = 2'b00;
    fails = 0;
    n_compared = 0;
    cycles = 0;
    for (int i = 0; i < 7; i++) begin
      rows[i] = '{i[2:0], 16'h0001 << i, 1'b1};
    end
    rows[7] = '{3'h0, 16'h0000, 1'b0};
    rows[8] = '{3'h5, 16'h005f, 1'b0};
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    rreg(framer_irq_pkg::MASK_OFFSET, 16'h0000);
    rreg(framer_irq_pkg::STATUS_OFFSET, 16'h0000);
    irq_at(1'b0);
    wreg(framer_irq_pkg::MASK_OFFSET, 16'hffff);
    rreg(framer_irq_pkg::MASK_OFFSET, 16'h007f);
    wreg(framer_irq_pkg::STATUS_OFFSET, 16'hffff);
    rreg(framer_irq_pkg::STATUS_OFFSET, 16'h0000);
    rreg(8'h40, 16'h0000);
    @(posedge mclk);
    ce <= 1'b0;
    wreg(framer_irq_pkg::MASK_OFFSET, 16'h0000);
    @(posedge mclk);
    ce <= 1'b1;
    rreg(framer_irq_pkg::MASK_OFFSET, 16'h007f);
    done("registers");
    // table runs in E3: idle bit checked as a latch only, not as meaning
    wreg(framer_irq_pkg::CONTROL_OFFSET, 16'h0003);
    foreach (rows[i]) run_row(rows[i]);
    done("bit table");
    // master mask off: event still pends and shows once master is set
    wreg(framer_irq_pkg::CONTROL_OFFSET, 16'h0002);
    wreg(framer_irq_pkg::MASK_OFFSET, 16'h0040);
    pulse(5, 1'b0);
    tick(2);
    irq_at(1'b0);
    wreg(framer_irq_pkg::CONTROL_OFFSET, 16'h0003);
    tick(1);
    irq_at(1'b1);
    rreg(framer_irq_pkg::STATUS_OFFSET, 16'h0040);
    irq_at(1'b0);
    pulse(5, 1'b0);
    tick(2);
    irq_at(1'b1);
    wreg(framer_irq_pkg::STATUS_OFFSET, 16'h0040);
    tick(1);
    irq_at(1'b0);
    rreg(framer_irq_pkg::STATUS_OFFSET, 16'h0040);
    done("master mask");
    // T3 frame loss windows, one short of the limit then at it
    wreg(framer_irq_pkg::CONTROL_OFFSET, 16'h0001);
    wreg(framer_irq_pkg::MASK_OFFSET, 16'h0000);
    pulse(2, 1'b0);
    for (int i = 0; i < 16; i++) pulse(0, i == 5 || i == 10);
    tick(2);
    rreg(framer_irq_pkg::STATUS_OFFSET, 16'h0000);
    pulse(0, 1'b1);
    tick(2);
    rreg(framer_irq_pkg::STATUS_OFFSET, 16'h0002);
    pulse(2, 1'b0);
    tick(2);
    rreg(framer_irq_pkg::STATUS_OFFSET, 16'h0002);
    rreg(framer_irq_pkg::STATUS_OFFSET, 16'h0000);
    for (int i = 0; i < 5; i++) pulse(1, i == 0 || i == 4);
    tick(2);
    rreg(framer_irq_pkg::STATUS_OFFSET, 16'h0000);
    pulse(1, 1'b1);
    tick(2);
    rreg(framer_irq_pkg::STATUS_OFFSET, 16'h0002);
    pulse(2, 1'b0);
    tick(2);
    rreg(framer_irq_pkg::STATUS_OFFSET, 16'h0002);
    rreg(framer_irq_pkg::STATUS_OFFSET, 16'h0000);
    done("frame loss");
    // remote alarm needs four multiframes each way
    repeat (3) pulse(3, 1'b0);
    tick(2);
    rreg(framer_irq_pkg::STATUS_OFFSET, 16'h0000);
    pulse(3, 1'b0);
    tick(2);
    rreg(framer_irq_pkg::STATUS_OFFSET, 16'h0008);
    repeat (3) pulse(3, 1'b1);
    tick(2);
    rreg(framer_irq_pkg::STATUS_OFFSET, 16'h0008);
    rreg(framer_irq_pkg::STATUS_OFFSET, 16'h0008);
    pulse(3, 1'b1);
    tick(2);
    rreg(framer_irq_pkg::STATUS_OFFSET, 16'h0008);
    rreg(framer_irq_pkg::STATUS_OFFSET, 16'h0000);
    done("remote alarm");
    wreg(framer_irq_pkg::CONTROL_OFFSET, 16'h0005);
    @(posedge mclk);
    far_code <= 1'b1;
    rreg(framer_irq_pkg::LIVE_OFFSET, 16'h0020);
    wreg(framer_irq_pkg::CONTROL_OFFSET, 16'h0007);
    rreg(framer_irq_pkg::LIVE_OFFSET, 16'h0000);
    done("code alarm");
    // mid-run reset drops a pending request, masks and modes
    wreg(framer_irq_pkg::MASK_OFFSET, 16'h0040);
    pulse(5, 1'b0);
    tick(2);
    irq_at(1'b1);
    @(posedge mclk);
    rst <= 1'b1;
    tick(3);
    rst <= 1'b0;
    irq_at(1'b0);
    rreg(framer_irq_pkg::MASK_OFFSET, 16'h0000);
    rreg(framer_irq_pkg::CONTROL_OFFSET, 16'h0000);
    rreg(framer_irq_pkg::STATUS_OFFSET, 16'h0000);
    done("reset");
    end_sim();
  end
endmodule : testbench
`default_nettype wire
